// *** rtl/swbm_map.vh ***
// Constants for the sleep wake-up timer and battery monitor block
`ifndef SWBM_MAP_VH
`define SWBM_MAP_VH

// Register offsets on the register port
`define SWBM_OFS_STATUS1      8'h03
`define SWBM_OFS_STATUS2      8'h04
`define SWBM_OFS_WAKE_EXPFINE 8'h14
`define SWBM_OFS_WAKE_MANT_HI 8'h15
`define SWBM_OFS_WAKE_MANT_LO 8'h16
`define SWBM_OFS_WAKE_CNT_HI  8'h17
`define SWBM_OFS_WAKE_CNT_LO  8'h18
`define SWBM_OFS_BAT_THRESH   8'h1a
`define SWBM_OFS_BAT_LEVEL    8'h1b

// Field positions
`define SWBM_EXP_MSB          5
`define SWBM_EXP_LSB          2
`define SWBM_FINE_MSB         1
`define SWBM_FINE_LSB         0
`define SWBM_CODE_MSB         4
`define SWBM_STAT_WAKE_BIT    3
`define SWBM_STAT_BAT_BIT     2

// Reset values
`define SWBM_RST_EXPFINE      8'h00
`define SWBM_RST_MANT         8'h00
`define SWBM_RST_THRESH       5'h14

// Timing
`define SWBM_MCLK_HZ          24'd10000000
`define SWBM_LF_HZ            24'd32768
`define SWBM_PERIOD_TICK_MULT 18'h00004
`define SWBM_BAT_PERIOD_TICKS 32768
`define SWBM_BAT_ON_US        250
// Window length in mclk cycles at 10 MHz; the product of the window in
// microseconds and the clock rate would overflow 32-bit arithmetic
`define SWBM_BAT_ON_CYCLES    12'd2500
`define SWBM_BAT_BELOW_RUN    3'h4

`endif

// *** rtl/swbm_sync.v ***
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module swbm_sync #(
  parameter WIDTH = 1
) (
  input  wire             mclk,   // System clock
  input  wire             reset,  // Synchronous reset, active high
  input  wire [WIDTH-1:0] d_in,   // Asynchronous input
  output wire [WIDTH-1:0] q_out   // Synchronised level
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge mclk) begin
    if (reset) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule // swbm_sync

// *** rtl/swbm_top.v ***
// Wake-up timer and low battery monitor of the housekeeping logic
`timescale 1ns/1ns
`include "swbm_map.vh"
module swbm_top #(
  parameter BAT_PERIOD_TICKS = `SWBM_BAT_PERIOD_TICKS
) (
  input  wire       mclk,                    // 10 MHz system clock
  input  wire       reset,                   // Synchronous reset, active high
  input  wire [7:0] reg_addr,                // Register address
  input  wire [7:0] reg_wdata,               // Register write data
  input  wire       reg_we,                  // Register write strobe
  input  wire       reg_re,                  // Register read strobe
  output wire [7:0] reg_rdata,               // Read data, valid cycle after strobe
  input  wire       sleep_mode,              // Chip is in sleep
  input  wire       wake_timer_enable,       // Run wake timer in sleep
  input  wire       wake_irq_enable,         // Wake timer interrupt enable
  input  wire       wake_gpio_route,         // Wake timer function routed to pin zero
  input  wire       battery_monitor_enable,  // Battery monitor enable
  input  wire       battery_irq_enable,      // Battery interrupt enable
  input  wire       low_freq_crystal_select, // Use external 32 kHz crystal
  input  wire [4:0] battery_code,            // Converter output code
  input  wire       general_pin_zero_in,     // Pin zero input level
  output wire       general_pin_zero_out,    // Pin zero output level
  output wire       general_pin_zero_oe,     // Pin zero output enable
  output wire       interrupt_pin_n,         // Interrupt pin, active low
  output wire       sleep_exit,              // One-cycle request to leave sleep
  output wire       crystal_30m_enable,      // Keep 30 MHz crystal running
  output wire       rc_osc_enable,           // Internal RC oscillator on
  output wire       battery_power            // Monitor and converter powered
);

  // Pin zero level through two flops before any logic reads it
  wire       xtal_lvl;
  swbm_sync #(.WIDTH(1)) u_sync_pin (
    .mclk  (mclk),
    .reset (reset),
    .d_in  (general_pin_zero_in),
    .q_out (xtal_lvl)
  );

  // Converter code through its own two flops; its bits are not gray
  // coded and may settle a cycle apart, so see the filter below
  wire [4:0] code_sync;
  swbm_sync #(.WIDTH(5)) u_sync_code (
    .mclk  (mclk),
    .reset (reset),
    .d_in  (battery_code),
    .q_out (code_sync)
  );

  // Code is only taken once two samples in a row agree, so a word
  // caught mid-change never reaches the threshold compare
  reg  [4:0] code_prev_r;
  reg  [4:0] code_s_r;
  wire [4:0] code_s = code_s_r;
  always @(posedge mclk) begin
    if (reset) begin
      code_prev_r <= 5'h00;
      code_s_r    <= 5'h00;
    end else begin
      code_prev_r <= code_sync;
      if (code_sync == code_prev_r) begin
        code_s_r <= code_sync;
      end
    end
  end

  // Registers
  reg [7:0]  expfine_r;
  reg [7:0]  mant_hi_r;
  reg [7:0]  mant_lo_r;
  reg [4:0]  thresh_r;
  reg [4:0]  bat_level_r;
  reg [7:0]  rdata_r;
  reg [7:0]  cnt_lo_snap_r;
  reg [23:0] acc_r;
  reg        xtal_prev_r;
  reg        sleep_prev_r;
  reg        wake_run_r;
  reg [17:0] pre_r;
  reg [15:0] wcnt_r;
  reg        wake_flag_r;
  reg        bat_flag_r;
  reg        irq_n_r;
  reg        exit_r;
  reg        pin_pulse_r;
  reg [15:0] bat_tick_r;
  reg [11:0] bat_on_r;
  reg        bat_pwr_r;
  reg [2:0]  below_r;

  // RC oscillator modelled as a fractional divider of mclk; the
  // accumulator keeps the long-term rate exact at 32.768 kHz
  wire [23:0] acc_sum = acc_r + `SWBM_LF_HZ;
  wire        rc_tick = (acc_sum >= `SWBM_MCLK_HZ);
  always @(posedge mclk) begin
    if (reset) begin
      acc_r <= 24'h000000;
    end else if (rc_tick) begin
      acc_r <= acc_sum - `SWBM_MCLK_HZ;
    end else begin
      acc_r <= acc_sum;
    end
  end

  // External crystal edge detect on the synchronised pin level
  always @(posedge mclk) begin
    if (reset) begin
      xtal_prev_r <= 1'b0;
    end else begin
      xtal_prev_r <= xtal_lvl;
    end
  end
  wire xtal_tick = xtal_lvl & ~xtal_prev_r;

  // Low-frequency tick source selection
  wire lf_tick = low_freq_crystal_select ? xtal_tick : rc_tick;

  // Period fields
  wire [3:0]  wexp  = expfine_r[`SWBM_EXP_MSB:`SWBM_EXP_LSB];
  wire [1:0]  wfine = expfine_r[`SWBM_FINE_MSB:`SWBM_FINE_LSB];
  wire [15:0] wmant = {mant_hi_r, mant_lo_r};

  // Prescale of 4 * 2^R ticks, divided by 2^D for finer steps; a fine
  // shift past the prescale leaves one tick per count, and a mantissa
  // of zero never expires
  wire [17:0] pre_lim  = (`SWBM_PERIOD_TICK_MULT << wexp) >> wfine;
  wire [17:0] pre_last = (pre_lim == 18'h00000) ? 18'h00000 : pre_lim - 18'h00001;
  wire        pre_wrap = wake_run_r & lf_tick & (pre_r == pre_last);
  wire        expire   = pre_wrap & (wmant != 16'h0000) &
                         (wcnt_r == wmant - 16'h0001);

  // Timer arms on sleep entry only when enabled at that moment
  wire sleep_entry = sleep_mode & ~sleep_prev_r;
  always @(posedge mclk) begin
    if (reset) begin
      sleep_prev_r <= 1'b0;
      wake_run_r   <= 1'b0;
    end else begin
      sleep_prev_r <= sleep_mode;
      if (!wake_timer_enable) begin
        wake_run_r <= 1'b0;
      end else if (sleep_entry) begin
        wake_run_r <= 1'b1;
      end
    end
  end

  // Prescaler and running count; count restarts after each expiry
  always @(posedge mclk) begin
    if (reset) begin
      pre_r  <= 18'h00000;
      wcnt_r <= 16'h0000;
    end else if (!wake_run_r || (sleep_entry && wake_timer_enable)) begin
      pre_r  <= 18'h00000;
      wcnt_r <= 16'h0000;
    end else if (lf_tick) begin
      if (pre_wrap) begin
        pre_r  <= 18'h00000;
        wcnt_r <= expire ? 16'h0000 : wcnt_r + 16'h0001;
      end else begin
        pre_r <= pre_r + 18'h00001;
      end
    end
  end

  // Expiry shown on pin zero for one low-frequency tick when the
  // interrupt is off; the block itself does not change state then
  always @(posedge mclk) begin
    if (reset) begin
      pin_pulse_r <= 1'b0;
    end else if (expire && !wake_irq_enable && wake_gpio_route) begin
      pin_pulse_r <= 1'b1;
    end else if (lf_tick) begin
      pin_pulse_r <= 1'b0;
    end
  end

  // Pin zero is an input while the crystal is selected
  assign general_pin_zero_oe  = ~low_freq_crystal_select & wake_gpio_route;
  assign general_pin_zero_out = pin_pulse_r & ~low_freq_crystal_select;

  // Battery measurement scheduling: one power window per second
  wire bat_sched = battery_monitor_enable & lf_tick &
                   (bat_tick_r == BAT_PERIOD_TICKS - 1);
  // Window end, counted in the window counter's own 12 bits
  wire bat_done  = bat_pwr_r & (bat_on_r == `SWBM_BAT_ON_CYCLES - 12'd1);
  always @(posedge mclk) begin
    if (reset) begin
      bat_tick_r <= 16'h0000;
    end else if (!battery_monitor_enable) begin
      bat_tick_r <= 16'h0000;
    end else if (lf_tick) begin
      bat_tick_r <= bat_sched ? 16'h0000 : bat_tick_r + 16'h0001;
    end
  end

  // Power window counted in mclk cycles
  always @(posedge mclk) begin
    if (reset) begin
      bat_pwr_r <= 1'b0;
      bat_on_r  <= 12'h000;
    end else if (!battery_monitor_enable) begin
      bat_pwr_r <= 1'b0;
      bat_on_r  <= 12'h000;
    end else if (bat_done) begin
      bat_pwr_r <= 1'b0;
      bat_on_r  <= 12'h000;
    end else if (bat_pwr_r) begin
      bat_on_r <= bat_on_r + 12'h001;
    end else if (bat_sched) begin
      bat_pwr_r <= 1'b1;
    end
  end

  // Sample code at window end; count consecutive low readings
  wire below    = (code_s < thresh_r);
  wire bat_fire = bat_done & below & (below_r == (`SWBM_BAT_BELOW_RUN - 3'h1));
  always @(posedge mclk) begin
    if (reset) begin
      bat_level_r <= 5'h00;
      below_r     <= 3'h0;
    end else if (!battery_monitor_enable) begin
      below_r <= 3'h0;
    end else if (bat_done) begin
      bat_level_r <= code_s;
      if (!below) begin
        below_r <= 3'h0;
      end else if (bat_fire) begin
        below_r <= 3'h0;
      end else begin
        below_r <= below_r + 3'h1;
      end
    end
  end

  // Status flags; a new event wins over the clearing read
  // One read of the second status register clears both flags together
  wire stat_rd   = reg_re & (reg_addr == `SWBM_OFS_STATUS2);
  wire wake_set  = expire & wake_irq_enable;
  wire bat_set   = bat_fire & battery_irq_enable;
  wire wake_nxt  = wake_set | (wake_flag_r & ~stat_rd);
  wire bat_nxt   = bat_set | (bat_flag_r & ~stat_rd);
  always @(posedge mclk) begin
    if (reset) begin
      wake_flag_r <= 1'b0;
      bat_flag_r  <= 1'b0;
      irq_n_r     <= 1'b1;
      exit_r      <= 1'b0;
    end else begin
      wake_flag_r <= wake_nxt;
      bat_flag_r  <= bat_nxt;
      irq_n_r     <= ~(wake_nxt | bat_nxt);
      exit_r      <= wake_set;
    end
  end

  assign interrupt_pin_n    = irq_n_r;
  assign sleep_exit         = exit_r;
  // Crystal stays on while the wake interrupt is pending
  assign crystal_30m_enable = wake_flag_r;
  // RC runs whenever a timer or monitor needs ticks and the crystal is not selected
  assign rc_osc_enable      = ~low_freq_crystal_select &
                              (wake_run_r | battery_monitor_enable);
  assign battery_power      = bat_pwr_r;

  // Register writes
  always @(posedge mclk) begin
    if (reset) begin
      expfine_r <= `SWBM_RST_EXPFINE;
      mant_hi_r <= `SWBM_RST_MANT;
      mant_lo_r <= `SWBM_RST_MANT;
      thresh_r  <= `SWBM_RST_THRESH;
    end else if (reg_we) begin
      case (reg_addr)
        `SWBM_OFS_WAKE_EXPFINE: expfine_r <= {2'b00, reg_wdata[5:0]};
        `SWBM_OFS_WAKE_MANT_HI: mant_hi_r <= reg_wdata;
        `SWBM_OFS_WAKE_MANT_LO: mant_lo_r <= reg_wdata;
        `SWBM_OFS_BAT_THRESH:   thresh_r  <= reg_wdata[`SWBM_CODE_MSB:0];
        default: ;
      endcase
    end
  end

  // Low byte captured with the high byte so a pair reads coherently
  always @(posedge mclk) begin
    if (reset) begin
      cnt_lo_snap_r <= 8'h00;
    end else if (reg_re && reg_addr == `SWBM_OFS_WAKE_CNT_HI) begin
      cnt_lo_snap_r <= wcnt_r[7:0];
    end
  end

  // Status word: wake and battery flags at their own bit positions
  reg [7:0] status_word;
  always @* begin
    status_word                      = 8'h00;
    status_word[`SWBM_STAT_WAKE_BIT] = wake_flag_r;
    status_word[`SWBM_STAT_BAT_BIT]  = bat_flag_r;
  end

  // Read data, registered; unmapped addresses read zero
  always @(posedge mclk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (reg_re) begin
      case (reg_addr)
        `SWBM_OFS_STATUS1:      rdata_r <= 8'h00; // No flags of this block live here
        `SWBM_OFS_STATUS2:      rdata_r <= status_word;
        `SWBM_OFS_WAKE_EXPFINE: rdata_r <= expfine_r;
        `SWBM_OFS_WAKE_MANT_HI: rdata_r <= mant_hi_r;
        `SWBM_OFS_WAKE_MANT_LO: rdata_r <= mant_lo_r;
        `SWBM_OFS_WAKE_CNT_HI:  rdata_r <= wcnt_r[15:8];
        `SWBM_OFS_WAKE_CNT_LO:  rdata_r <= cnt_lo_snap_r;
        `SWBM_OFS_BAT_THRESH:   rdata_r <= {3'b000, thresh_r};
        `SWBM_OFS_BAT_LEVEL:    rdata_r <= {3'b000, bat_level_r};
        default:                rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

endmodule // swbm_top

// *** tb/swbm_assertions.sv ***
// Port checker for the wake timer and battery monitor
`timescale 1ns/1ns
module swbm_chk (
  input wire       mclk,                    // Clock
  input wire       reset,                   // Reset
  input wire [7:0] reg_addr,                // Address
  input wire       reg_re,                  // Read strobe
  input wire [7:0] reg_rdata,               // Read data
  input wire       sleep_mode,              // Asleep
  input wire       wake_irq_enable,         // Wake irq on
  input wire       wake_gpio_route,         // Pin route
  input wire       battery_monitor_enable,  // Monitor on
  input wire       low_freq_crystal_select, // Crystal on pin
  input wire       general_pin_zero_out,    // Pin level
  input wire       general_pin_zero_oe,     // Pin enable
  input wire       interrupt_pin_n,         // Irq, low
  input wire       sleep_exit,              // Leave sleep
  input wire       crystal_30m_enable,      // Crystal run
  input wire       rc_osc_enable,           // RC on
  input wire       battery_power            // Monitor power
);
  reg [11:0] on_cnt_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Length of the running power window, kept one cycle after it ends, then zero
  always @(posedge mclk) begin
    if (reset || !battery_power)
      on_cnt_r <= 12'h000;
    else
      on_cnt_r <= on_cnt_r + 12'h001;
  end
  property p_quiet; disable iff (1'b0)
    reset |=> interrupt_pin_n && !sleep_exit && !battery_power && !crystal_30m_enable; endproperty
  a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
  property p_exit; sleep_exit |=> !sleep_exit; endproperty
  a_exit: assert property (p_exit) else $error("sleep exit too long");
  property p_exit_irq; sleep_exit |-> !interrupt_pin_n && crystal_30m_enable && wake_irq_enable;
  endproperty
  a_exit_irq: assert property (p_exit_irq) else $error("wake without irq");
  property p_oe; general_pin_zero_oe == (!low_freq_crystal_select && wake_gpio_route); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_power; battery_power |-> $past(battery_monitor_enable); endproperty
  a_power: assert property (p_power) else $error("monitor powered while off");
  property p_window; $fell(battery_power) && battery_monitor_enable |-> on_cnt_r == 12'h9c4;
  endproperty
  a_window: assert property (p_window) else $error("window length wrong");
  property p_rc;
    sleep_mode && battery_monitor_enable && !low_freq_crystal_select |-> ##[0:2] rc_osc_enable;
  endproperty
  a_rc: assert property (p_rc) else $error("RC off in sleep");
  property p_level; reg_re && reg_addr == 8'h1b |=> reg_rdata[7:5] == 3'h0; endproperty
  a_level: assert property (p_level) else $error("level upper bits set");
  property p_hold; !interrupt_pin_n && !(reg_re && reg_addr == 8'h04) |=> !interrupt_pin_n;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped unread");
  c_exit: cover property (sleep_exit);
  c_meas: cover property ($fell(battery_power));
  c_pin: cover property ($rose(general_pin_zero_out));
endmodule // swbm_chk

bind swbm_top swbm_chk swbm_chk_inst (.*);

// *** tb/swbm_host_model.sv ***
// Host controller model: register master and crystal source
`timescale 1ns/1ns
module swbm_host_model (
  input  wire       mclk,                       // Clock
  output reg  [7:0] reg_addr = 8'h00,           // Address
  output reg  [7:0] reg_wdata = 8'h00,          // Write data
  output reg        reg_we = 1'b0,              // Write strobe
  output reg        reg_re = 1'b0,              // Read strobe
  input  wire [7:0] reg_rdata,                  // Read data
  input  wire       xtal_run,                   // Crystal runs
  output reg        general_pin_zero_in = 1'b0  // Crystal clock
);
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_we <= 1'b1;
      @(posedge mclk);
      reg_we <= 1'b0;
    end
  endtask
  // Data lands one edge after the strobe is taken; a 04h read clears flags
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge mclk);
      reg_re <= 1'b0;
      @(posedge mclk);
      v = reg_rdata;
    end
  endtask
  // Crystal near 32.768 kHz; stands still when stopped
  always begin
    #15259;
    if (xtal_run)
      general_pin_zero_in = ~general_pin_zero_in;
  end
endmodule // swbm_host_model

// *** tb/tb_top.sv ***
// Self-checking bench for the wake timer and battery monitor
`timescale 1ns/1ns
module tb_top;
  reg mclk = 1'b0, reset = 1'b1, sleep_mode = 1'b0, xtal_run = 1'b0;
  reg wake_timer_enable = 1'b0, wake_irq_enable = 1'b0, wake_gpio_route = 1'b0;
  reg battery_monitor_enable = 1'b0, battery_irq_enable = 1'b0;
  reg low_freq_crystal_select = 1'b0;
  reg [4:0] battery_code = 5'h1f;
  reg [15:0] c1, c2;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_we, reg_re, general_pin_zero_in, general_pin_zero_out, general_pin_zero_oe;
  wire interrupt_pin_n, sleep_exit, crystal_30m_enable, rc_osc_enable, battery_power;
  integer err_count = 0, check_count = 0, cyc = 0, n, k;
  always #50 mclk = ~mclk;
  swbm_top #(.BAT_PERIOD_TICKS(16)) swbm_top_inst (.*);
  swbm_host_model swbm_host_model_inst (.*);
  // Cycle ceiling; a hang counts as a mismatch
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  task check(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bit_is(input b, input e);
    check({7'h00, b}, {7'h00, e});
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      swbm_host_model_inst.rd(a, c1[7:0]);
      check(c1[7:0], e);
    end
  endtask
  task period(input [7:0] lo);
    begin
      swbm_host_model_inst.wr(8'h14, 8'h00);
      swbm_host_model_inst.wr(8'h16, lo);
    end
  endtask
  // Sleep is left and entered again so the timer sees a fresh entry
  task nap(input en, input ie);
    begin
      @(posedge mclk);
      sleep_mode <= 1'b0;
      wake_timer_enable <= en;
      wake_irq_enable <= ie;
      @(posedge mclk);
      sleep_mode <= 1'b1;
    end
  endtask
  task wait_low(input integer lim);
    for (n = 0; interrupt_pin_n !== 1'b0 && n < lim; n = n + 1)
      @(posedge mclk);
  endtask
  task wait_meas;
    begin
      for (n = 0; battery_power !== 1'b1 && n < 8000; n = n + 1)
        @(posedge mclk);
      for (n = n; battery_power !== 1'b0 && n < 12000; n = n + 1)
        @(posedge mclk);
      repeat (4) @(posedge mclk);
      bit_is(n < 12000, 1'b1);
    end
  endtask
  task test_regs;
    begin
      rdc(8'h14, 8'h00);
      rdc(8'h15, 8'h00);
      rdc(8'h1a, 8'h14);
      rdc(8'h20, 8'h00);
      swbm_host_model_inst.wr(8'h14, 8'h3d);
      rdc(8'h14, 8'h3d);
      swbm_host_model_inst.wr(8'h1a, 8'h0a);
      rdc(8'h1a, 8'h0a);
      $display("register test done");
    end
  endtask
  task test_wake;
    begin
      period(8'h01);
      nap(1'b0, 1'b1);
      wait_low(1600);
      bit_is(interrupt_pin_n, 1'b1);
      nap(1'b1, 1'b1);
      wait_low(3000);
      bit_is(n > 900 && n < 1260, 1'b1);
      bit_is(crystal_30m_enable, 1'b1);
      rdc(8'h04, 8'h08);
      bit_is(interrupt_pin_n, 1'b1);
      $display("wake test done");
    end
  endtask
  task test_gpio;
    begin
      period(8'h02);
      nap(1'b1, 1'b0);
      wake_gpio_route <= 1'b1;
      swbm_host_model_inst.rd(8'h17, c2[15:8]);
      swbm_host_model_inst.rd(8'h18, c2[7:0]);
      repeat (1500) @(posedge mclk);
      swbm_host_model_inst.rd(8'h17, c1[15:8]);
      swbm_host_model_inst.rd(8'h18, c1[7:0]);
      bit_is(c1 !== c2, 1'b1);
      for (n = 0; general_pin_zero_out !== 1'b1 && n < 3000; n = n + 1)
        @(posedge mclk);
      bit_is(general_pin_zero_oe && n < 3000, 1'b1);
      bit_is(interrupt_pin_n, 1'b1);
      rdc(8'h04, 8'h00);
      $display("pin test done");
    end
  endtask
  task test_xtal;
    begin
      period(8'h01);
      low_freq_crystal_select <= 1'b1;
      nap(1'b1, 1'b1);
      wait_low(2000);
      bit_is(interrupt_pin_n | general_pin_zero_oe, 1'b1);
      xtal_run <= 1'b1;
      wait_low(2000);
      bit_is(interrupt_pin_n | general_pin_zero_oe, 1'b0);
      rdc(8'h04, 8'h08);
      xtal_run <= 1'b0;
      low_freq_crystal_select <= 1'b0;
      wake_gpio_route <= 1'b0;
      $display("crystal test done");
    end
  endtask
  // Code equal to the threshold never fires; four low readings do
  task test_batt;
    begin
      nap(1'b0, 1'b0);
      battery_code <= 5'h0a;
      battery_irq_enable <= 1'b1;
      battery_monitor_enable <= 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
        wait_meas;
        bit_is(interrupt_pin_n, 1'b1);
      end
      rdc(8'h1b, 8'h0a);
      battery_code <= 5'h09;
      for (k = 1; k < 5; k = k + 1) begin
        wait_meas;
        bit_is(interrupt_pin_n, k < 4);
      end
      rdc(8'h04, 8'h04);
      rdc(8'h1b, 8'h09);
      battery_monitor_enable <= 1'b0;
      $display("battery test done");
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    test_regs;
    test_wake;
    test_gpio;
    test_xtal;
    test_batt;
    end_of_test;
  end
endmodule // tb_top
